// ### rtl/blank_timer.sv
// One blanking timer: counts hclk cycles while run is high.
// Assumes run comes from logic on hclk; dropping run clears the count.
module blank_timer #(
  parameter int unsigned CYCLES = 4
) (
  // Clock and reset
  input  wire logic     hclk,
  input  wire logic     hresetn,
  // Control side
  blank_timer_if.timer  tmr
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_reg;
  logic          done_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end else if (!tmr.run) begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end else if (!done_reg) begin
      count_reg <= count_reg + CW'(1);
      done_reg  <= (count_reg == LAST);
    end
  end

  assign tmr.done = done_reg;

endmodule : blank_timer

// ### rtl/blank_timer_if.sv
// Run and expiry signals between the controller and one blanking timer.
// Both ends sit on the same clock.
interface blank_timer_if;
  logic run;
  logic done;

  modport ctrl  (output run, input done);
  modport timer (input run, output done);
endinterface : blank_timer_if

// ### rtl/burst_restart_ctrl.sv
// Burst mode and auto-restart mode control with an AHB-Lite register slave.
// Assumes digitised comparator and fault levels from the analog side, asynchronous to hclk.
// Summary of operation
// R1: Both burst and auto-restart entry wait a 20 ms internal blanking interval.
// R2: Burst uses basic blanking only; auto-restart also waits for the capacitor extension.
// R3: After 20 ms blanking expires the clamp switch opens, letting the blanking pin rise.
// R4: No auto-restart until the blanking-pin comparator reports 4.0 V.
// R5: When the qualify gate is true, wait 30 us then enter auto-restart.
// R6: Burst counter held at zero normally, runs while feedback is below 1.35 V.
// R7: Enter burst when the counter reaches 20 ms with feedback still low.
// R8: On burst entry set the burst flag and switch off the bias.
// R9: Keep the startup cell off throughout burst mode.
// R10: In burst, feedback above 3.5 V re-enables bias and switching.
// R11: In burst, select the reduced 0.34 V current limit.
// R12: In burst, feedback down to 3.0 V switches bias and switching off again.
// R13: Feedback above 4.0 V in burst leaves burst and restores full limit.
// R14: Feedback above 4.0 V starts the overload counter; at 20 ms release the clamp.
// R15: Only overload and open loop are blanked; other faults restart immediately.
// R16: Auto-restart stops switching; cell on at turn-off, off at turn-on, then soft start.
// R17: After soft start recheck faults; restart again if present, else resume normal.
// R18: The external blanking capacitor must stay below 0.65 uF.
// R19: Soft start runs at every restart attempt as at power-up.
// R20: Feedback crossing back before expiry clears that counter without a mode change.
// R21: All blanking intervals count cycles of hclk, not switching cycles.
module burst_restart_ctrl
  import burst_restart_pkg::*;
#(
  parameter int unsigned BLANK_CNT = BLANK_CYCLES,
  parameter int unsigned SPIKE_CNT = SPIKE_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Feedback and blanking-pin comparators
  input  wire logic        fb_low_comparator,
  input  wire logic        fb_high_comparator,
  input  wire logic        burst_wake_comparator,
  input  wire logic        burst_sleep_comparator,
  input  wire logic        ba_level_comparator,
  // Fault monitors and supply thresholds
  input  wire logic        vcc_overvoltage,
  input  wire logic        over_temperature,
  input  wire logic        vcc_undervoltage,
  input  wire logic        short_optocoupler,
  input  wire logic        ext_restart_enable,
  input  wire logic        vcc_turn_off,
  input  wire logic        vcc_turn_on,
  input  wire logic        soft_start_done,
  // Mode outputs
  output logic             burst_flag,
  output logic             bias_enable,
  output logic             reduced_limit_sel,
  output logic             ba_clamp_release,
  output logic             restart_request,
  output logic             startup_cell_en,
  output logic             switching_en,
  output logic             soft_start_req
);

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic              fb_low_s;
  logic              fb_high_s;
  logic              wake_s;
  logic              sleep_s;
  logic              ba_level_s;
  logic              ovp_s;
  logic              otp_s;
  logic              uv_s;
  logic              opto_s;
  logic              ext_s;
  logic              vcc_off_s;
  logic              vcc_on_s;
  logic              ss_done_s;
  logic              imm_fault;
  state_t            state_reg;
  state_t            state_next;
  logic              bias_reg;
  logic              bias_next;
  logic [31:0]       ctrl_reg;
  logic              wr_pend_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              addr_phase;
  logic [31:0]       status_word;

  blank_timer_if burst_tmr ();
  blank_timer_if ovl_tmr ();
  blank_timer_if spike_tmr ();

  // Two-stage synchroniser for every pin level except low feedback
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {soft_start_done, vcc_turn_on, vcc_turn_off, ext_restart_enable,
                    short_optocoupler, vcc_undervoltage, over_temperature,
                    vcc_overvoltage, ba_level_comparator, burst_sleep_comparator,
                    burst_wake_comparator, fb_high_comparator};
      sync2_reg <= sync1_reg;
    end
  end

  assign fb_high_s  = sync2_reg[0];
  assign wake_s     = sync2_reg[1];
  assign sleep_s    = sync2_reg[2];
  assign ba_level_s = sync2_reg[3];
  assign ovp_s      = sync2_reg[4];
  assign otp_s      = sync2_reg[5];
  assign uv_s       = sync2_reg[6];
  assign opto_s     = sync2_reg[7];
  assign ext_s      = sync2_reg[8];
  assign vcc_off_s  = sync2_reg[9];
  assign vcc_on_s   = sync2_reg[10];
  assign ss_done_s  = sync2_reg[11];

  // Low-feedback comparator has its own pair of flops
  logic fb_low1_reg;
  logic fb_low2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_low1_reg <= 1'b0;
      fb_low2_reg <= 1'b0;
    end else begin
      fb_low1_reg <= fb_low_comparator;
      fb_low2_reg <= fb_low1_reg;
    end
  end
  assign fb_low_s = fb_low2_reg;

  // R15: unblanked faults
  assign imm_fault = ovp_s | otp_s | uv_s | opto_s | (ext_s & ctrl_reg[CTRL_EXT_ALLOW]);

  // R6: burst counter runs only in normal mode with low feedback
  // R20: feedback recovering drops run and clears the count
  // R21: counted on hclk
  assign burst_tmr.run = (state_reg == ST_NORMAL) && fb_low_s;
  // R14: overload counter runs with feedback above 4.0 V
  assign ovl_tmr.run   = (state_reg == ST_NORMAL) && fb_high_s;
  // R4: qualify gate needs both expiry and the blanking-pin level
  assign spike_tmr.run = (state_reg == ST_NORMAL) && ovl_tmr.done && ba_level_s;

  blank_timer #(.CYCLES(BLANK_CNT)) u_burst_blank (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tmr     (burst_tmr.timer)
  );

  blank_timer #(.CYCLES(BLANK_CNT)) u_ovl_blank (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tmr     (ovl_tmr.timer)
  );

  blank_timer #(.CYCLES(SPIKE_CNT)) u_spike_blank (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tmr     (spike_tmr.timer)
  );

  // Mode sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_NORMAL: begin
        // R15: immediate faults bypass blanking
        if (imm_fault) begin
          state_next = ST_OFF;
        // R5: restart after spike blanking
        end else if (spike_tmr.done) begin
          state_next = ST_OFF;
        // R1: R2: R7: burst after basic blanking only
        end else if (burst_tmr.done && fb_low_s) begin
          state_next = ST_BURST;
        end
      end
      ST_BURST: begin
        if (imm_fault) begin
          state_next = ST_OFF;
        // R13: high load leaves burst
        end else if (fb_high_s) begin
          state_next = ST_NORMAL;
        end
      end
      // R16: wait for turn-off, then charge to turn-on
      ST_OFF: begin
        if (vcc_off_s) begin
          state_next = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (vcc_on_s) begin
          state_next = ST_SOFT;
        end
      end
      // R17: recheck faults after soft start
      ST_SOFT: begin
        if (ss_done_s) begin
          state_next = imm_fault ? ST_OFF : ST_NORMAL;
        end
      end
      default: state_next = ST_CHARGE;
    endcase
  end

  // Burst bias hysteresis
  always_comb begin
    bias_next = 1'b1;
    if (state_next == ST_BURST) begin
      if (state_reg != ST_BURST) begin
        // R8: bias off on entry
        bias_next = 1'b0;
      // R10: wake above 3.5 V
      end else if (wake_s) begin
        bias_next = 1'b1;
      // R12: sleep at 3.0 V
      end else if (sleep_s) begin
        bias_next = 1'b0;
      end else begin
        bias_next = bias_reg;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_CHARGE;
      bias_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      bias_reg  <= bias_next;
    end
  end

  // Registered mode outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_flag        <= 1'b0;
      bias_enable       <= 1'b1;
      reduced_limit_sel <= 1'b0;
      ba_clamp_release  <= 1'b0;
      restart_request   <= 1'b0;
      startup_cell_en   <= 1'b1;
      switching_en      <= 1'b0;
      soft_start_req    <= 1'b0;
    end else begin
      // R8: R11: flag and reduced limit follow burst mode
      burst_flag        <= (state_next == ST_BURST);
      reduced_limit_sel <= (state_next == ST_BURST);
      bias_enable       <= bias_next;
      // R3: R14: clamp opens while overload blanking has expired
      ba_clamp_release  <= ovl_tmr.run && ovl_tmr.done;
      restart_request   <= (state_next == ST_OFF) || (state_next == ST_CHARGE);
      // R9: R16: cell on only while charging
      startup_cell_en   <= (state_next == ST_CHARGE);
      switching_en      <= (state_next == ST_NORMAL) || (state_next == ST_SOFT)
                           || ((state_next == ST_BURST) && bias_next);
      // R19: soft start on every turn-on
      soft_start_req    <= (state_reg == ST_CHARGE) && (state_next == ST_SOFT);
    end
  end

  // AHB-Lite slave, zero wait states
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

  assign status_word = {17'h0_0000, restart_request, switching_en, startup_cell_en,
                        ba_clamp_release, reduced_limit_sel, bias_enable, burst_flag,
                        3'h0, state_reg};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= '0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      addr_reg    <= haddr[ADDR_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_pend_reg && (addr_reg == ADDR_CTRL)) begin
      ctrl_reg <= {31'h0000_0000, hwdata[CTRL_EXT_ALLOW]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      case (haddr[ADDR_W-1:0])
        ADDR_CTRL:   hrdata <= ctrl_reg;
        ADDR_STATUS: hrdata <= status_word;
        default:     hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_charge_done;
    (state_reg == ST_CHARGE) && vcc_on_s;
  endsequence

  sequence s_soft_running;
    (state_reg == ST_SOFT) && soft_start_req && !startup_cell_en;
  endsequence

  a_burst_entry: assert property ( // R7
    (state_reg == ST_NORMAL) && burst_tmr.done && fb_low_s && !imm_fault
      && !spike_tmr.done |=> (state_reg == ST_BURST) && burst_flag && !bias_enable)
    else $error("burst not entered after blanking");

  a_burst_outputs: assert property ( // R11
    (state_reg == ST_BURST) |-> burst_flag && reduced_limit_sel && !startup_cell_en)
    else $error("burst outputs wrong");

  a_burst_wake: assert property ( // R10
    (state_reg == ST_BURST) && $rose(wake_s) && !fb_high_s && !imm_fault
      |=> bias_enable && switching_en)
    else $error("bias not restored on wake");

  a_burst_sleep: assert property ( // R12
    (state_reg == ST_BURST) && !wake_s && sleep_s && !fb_high_s && !imm_fault
      |=> !bias_enable && !switching_en)
    else $error("bias not cut on sleep");

  a_burst_exit: assert property ( // R13
    (state_reg == ST_BURST) && fb_high_s && !imm_fault
      |=> (state_reg == ST_NORMAL) && !reduced_limit_sel && !burst_flag)
    else $error("burst not left on high feedback");

  a_clamp_open: assert property ( // R14
    ovl_tmr.run && ovl_tmr.done |=> ba_clamp_release)
    else $error("clamp not released after blanking");

  a_restart_hold: assert property ( // R4
    (state_reg == ST_NORMAL) && !imm_fault && !spike_tmr.done
      |=> (state_reg != ST_OFF))
    else $error("restart without qualify path");

  a_spike_restart: assert property ( // R5
    (state_reg == ST_NORMAL) && spike_tmr.done |=> restart_request && !switching_en)
    else $error("restart not taken after spike blanking");

  a_fast_fault: assert property ( // R15
    ((state_reg == ST_NORMAL) || (state_reg == ST_BURST)) && imm_fault
      |=> (state_reg == ST_OFF) ##1 restart_request)
    else $error("immediate fault not taken");

  a_cell_on: assert property ( // R16
    (state_reg == ST_OFF) && vcc_off_s |=> startup_cell_en && !switching_en)
    else $error("startup cell not enabled");

  a_soft_start: assert property ( // R19
    s_charge_done |=> s_soft_running ##1 !soft_start_req)
    else $error("soft start not begun at turn-on");

  a_recheck: assert property ( // R17
    (state_reg == ST_SOFT) && ss_done_s
      |=> (state_reg == ($past(imm_fault) ? ST_OFF : ST_NORMAL)))
    else $error("fault recheck wrong");

endmodule : burst_restart_ctrl

// ### rtl/burst_restart_pkg.sv
// Constants, register map and state encoding for the burst and auto-restart control.
// Assumes a 200 MHz hclk; every blanking time is counted on that clock.
package burst_restart_pkg;

  // Timebase
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned BLANK_TIME_NS   = 20_000_000;
  localparam int unsigned SPIKE_TIME_NS   = 30_000;
  localparam int unsigned BLANK_CYCLES    = BLANK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SPIKE_CYCLES    = SPIKE_TIME_NS / CLK_PERIOD_NS;

  // Register map, byte offsets within the slave
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_STATUS     = 12'h004;

  // Control register fields
  localparam int unsigned CTRL_EXT_ALLOW  = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

  // Status register fields
  localparam int unsigned STAT_STATE_LSB  = 0;
  localparam int unsigned STAT_BURST      = 8;
  localparam int unsigned STAT_BIAS       = 9;
  localparam int unsigned STAT_LIMIT      = 10;
  localparam int unsigned STAT_CLAMP      = 11;
  localparam int unsigned STAT_STARTUP    = 12;
  localparam int unsigned STAT_SWITCH     = 13;
  localparam int unsigned STAT_RESTART    = 14;

  // AHB-Lite codes
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'h0;

  // Number of pin inputs passing the synchroniser
  localparam int unsigned SYNC_W          = 12;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_BURST  = 5'h02,
    ST_OFF    = 5'h04,
    ST_CHARGE = 5'h08,
    ST_SOFT   = 5'h10
  } state_t;

endpackage : burst_restart_pkg

// ### verif/analog_side_model.sv
// Stand-in for the analog side: comparators, blanking pin, supply and soft start.
// Assumes feedback in mV from the bench and controller outputs on hclk.
module analog_side_model
  import burst_restart_pkg::*;
#(
  parameter int unsigned VCC_SPAN = 12,
  parameter int unsigned SOFT_LEN = 10
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bench stimulus
  input  wire logic [12:0] fb_mv,
  input  wire logic [7:0]  ba_charge,
  // Controller outputs
  input  wire logic        ba_clamp_release,
  input  wire logic        startup_cell_en,
  input  wire logic        switching_en,
  input  wire logic        burst_flag,
  input  wire logic        soft_start_req,
  // Comparator and supply levels
  output logic             fb_low_comparator,
  output logic             fb_high_comparator,
  output logic             burst_wake_comparator,
  output logic             burst_sleep_comparator,
  output logic             ba_level_comparator,
  output logic             vcc_turn_off,
  output logic             vcc_turn_on,
  output logic             soft_start_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ba_cnt;
  logic [7:0] vcc;
  logic [7:0] soft_cnt;
  logic       soft_busy;

  // Thresholds 1.35 V, 4.0 V, 3.5 V, 3.0 V
  assign fb_low_comparator      = fb_mv < 13'h546;
  assign fb_high_comparator     = fb_mv > 13'hFA0;
  assign burst_wake_comparator  = fb_mv > 13'hDAC;
  assign burst_sleep_comparator = fb_mv <= 13'hBB8;

  // pin charges only while clamp open
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ba_cnt <= 8'h00;
    else if (!ba_clamp_release) ba_cnt <= 8'h00;
    else if (ba_cnt < ba_charge) ba_cnt <= ba_cnt + 8'h01;
  end
  assign ba_level_comparator = ba_clamp_release && (ba_cnt >= ba_charge);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) vcc <= 8'h00;
    else if (startup_cell_en) begin
      if (vcc < 8'(VCC_SPAN)) vcc <= vcc + 8'h01;
    end else if (!(switching_en || burst_flag || soft_busy) && vcc != 8'h00) vcc <= vcc - 8'h01;
  end
  assign vcc_turn_off = (vcc == 8'h00);
  assign vcc_turn_on  = (vcc >= 8'(VCC_SPAN));

  // soft start restarts on each request, resets while chip is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_cnt        <= 8'h00;
      soft_start_done <= 1'h0;
    end else if (soft_start_req) begin
      soft_cnt        <= 8'(SOFT_LEN);
      soft_start_done <= 1'h0;
    end else if (startup_cell_en) begin
      soft_cnt        <= 8'h00;
      soft_start_done <= 1'h0;
    end else if (soft_cnt == 8'h01) begin
      soft_cnt        <= 8'h00;
      soft_start_done <= 1'h1;
    end else if (soft_cnt != 8'h00) soft_cnt <= soft_cnt - 8'h01;
  end
  assign soft_busy = (soft_cnt != 8'h00);
endmodule : analog_side_model

// ### verif/tb_top.sv
// Self-checking bench for the burst and auto-restart control.
// Assumes shortened blanking counts and the analog stand-in model.
module tb_top;
  import burst_restart_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BLK = 20;
  localparam int SPK = 4;
  localparam int B_BURST = 0, B_BIAS = 1, B_LIM = 2, B_CLAMP = 3;
  localparam int B_RST = 4, B_CELL = 5, B_SW = 6, B_SOFT = 7;
  logic        hclk = 1'h0, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [12:0] fb_mv;
  logic [7:0]  ba_charge, outs;
  logic [4:0]  flt;
  logic        fbl, fbh, wake, sleep, bal, voff, von, ssd;
  logic        burst_flag, bias_enable, reduced_limit_sel, ba_clamp_release;
  logic        restart_request, startup_cell_en, switching_en, soft_start_req;
  int          errors, cmp_count, cyc;

  always #2.5 hclk = ~hclk;
  assign outs = {soft_start_req, switching_en, startup_cell_en, restart_request,
                 ba_clamp_release, reduced_limit_sel, bias_enable, burst_flag};

  burst_restart_ctrl #(.BLANK_CNT(BLK), .SPIKE_CNT(SPK)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fb_low_comparator(fbl), .fb_high_comparator(fbh), .burst_wake_comparator(wake),
    .burst_sleep_comparator(sleep), .ba_level_comparator(bal),
    .vcc_overvoltage(flt[0]), .over_temperature(flt[1]), .vcc_undervoltage(flt[2]),
    .short_optocoupler(flt[3]), .ext_restart_enable(flt[4]),
    .vcc_turn_off(voff), .vcc_turn_on(von), .soft_start_done(ssd),
    .burst_flag(burst_flag), .bias_enable(bias_enable),
    .reduced_limit_sel(reduced_limit_sel), .ba_clamp_release(ba_clamp_release),
    .restart_request(restart_request), .startup_cell_en(startup_cell_en),
    .switching_en(switching_en), .soft_start_req(soft_start_req));

  analog_side_model part_u (
    .hclk(hclk), .hresetn(hresetn), .fb_mv(fb_mv), .ba_charge(ba_charge),
    .ba_clamp_release(ba_clamp_release), .startup_cell_en(startup_cell_en),
    .switching_en(switching_en), .burst_flag(burst_flag), .soft_start_req(soft_start_req),
    .fb_low_comparator(fbl), .fb_high_comparator(fbh), .burst_wake_comparator(wake),
    .burst_sleep_comparator(sleep), .ba_level_comparator(bal),
    .vcc_turn_off(voff), .vcc_turn_on(von), .soft_start_done(ssd));

  task automatic test_done();
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  always @(posedge hclk) begin
    cyc++;
    if (cyc > 30000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [12:0] lvl(input int base, input int span);
    return 13'(base + $urandom % span);
  endfunction : lvl

  function automatic logic in_win(input int n, input int lo, input int span);
    return (n >= lo) && (n <= lo + span);
  endfunction : in_win

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'h1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= wr;
    // Only the bench timeout ends a wait for ready
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask : ahb

  task automatic wait_for(input int b, input logic v, input int lim, output int n);
    n = 0;
    while (outs[b] !== v && n < lim) begin @(negedge hclk); n++; end
  endtask : wait_for

  task automatic wait_normal(output logic [31:0] s);
    int n;
    n = 0;
    do begin ahb(1'h0, {20'h0, ADDR_STATUS}, 32'h0, s); n++; end
    while (s[4:0] !== ST_NORMAL && n < 300);
  endtask : wait_normal

  task automatic step_fb(input logic [12:0] v);
    @(posedge hclk);
    fb_mv <= v;
  endtask : step_fb

  initial begin
    int n, k, i;
    logic [31:0] q;
    hsel = 1'h0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'h0; hsize = 3'h2;
    hwdata = 32'h0; fb_mv = 13'h7D0; ba_charge = 8'h00; flt = 5'h00; hresetn = 1'h0;
    errors = 0; cmp_count = 0; cyc = 0;
    void'($urandom(37028));
    // Reset values are looked at once clock edges have applied reset
    repeat (2) @(posedge hclk);
    chk("reset cell", startup_cell_en, 1'h1);
    chk("reset restart", restart_request, 1'h0);
    hresetn <= 1'h1;
    wait_normal(q);
    chk("power-up state", q[4:0], ST_NORMAL);
    ahb(1'h0, {20'h0, ADDR_CTRL}, 32'h0, q);
    chk("ctrl reset", q, CTRL_RESET);
    ahb(1'h1, {20'h0, ADDR_CTRL}, 32'hFFFF_FFFE, q);
    ahb(1'h0, {20'h0, ADDR_CTRL}, 32'h0, q);
    chk("ctrl bit0 only", q, 32'h0);
    ahb(1'h1, {20'h0, ADDR_CTRL}, 32'h1, q);
    ahb(1'h0, 32'h0000_0008, 32'h0, q);
    chk("unmapped read", q, 32'h0);
    chk("hresp", hresp, HRESP_OKAY);
    // Burst entry after a dip that must not count
    k = 3 + $urandom % (BLK - 8);
    step_fb(lvl(200, 1100));
    repeat (k) @(posedge hclk);
    fb_mv <= lvl(1400, 1500);
    repeat (6) @(posedge hclk);
    chk("burst after dip", burst_flag, 1'h0);
    fb_mv <= lvl(200, 1100);
    wait_for(B_BURST, 1'h1, BLK + 20, n);
    chk("burst blanking", in_win(n, BLK, 8), 1'h1);
    chk("burst bias", bias_enable, 1'h0);
    chk("burst limit", reduced_limit_sel, 1'h1);
    chk("burst cell", startup_cell_en, 1'h0);
    step_fb(13'hE10);
    wait_for(B_BIAS, 1'h1, 10, n);
    chk("wake bias", bias_enable, 1'h1);
    chk("wake switching", switching_en, 1'h1);
    step_fb(13'hB54);
    wait_for(B_BIAS, 1'h0, 10, n);
    chk("sleep bias", bias_enable, 1'h0);
    chk("sleep flag", burst_flag, 1'h1);
    step_fb(lvl(4100, 800));
    wait_for(B_BURST, 1'h0, 10, n);
    chk("leave burst", burst_flag, 1'h0);
    chk("leave limit", reduced_limit_sel, 1'h0);
    step_fb(lvl(1400, 1500));
    repeat (6) @(posedge hclk);
    // Overload through extended blanking
    ba_charge <= 8'(3 + $urandom % 20);
    k = 3 + $urandom % (BLK - 8);
    step_fb(lvl(4100, 800));
    repeat (k) @(posedge hclk);
    fb_mv <= lvl(1400, 1500);
    repeat (6) @(posedge hclk);
    chk("clamp after dip", ba_clamp_release, 1'h0);
    fb_mv <= lvl(4100, 800);
    wait_for(B_CLAMP, 1'h1, BLK + 20, n);
    chk("clamp blanking", in_win(n, BLK, 8), 1'h1);
    chk("no early restart", restart_request, 1'h0);
    wait_for(B_RST, 1'h1, ba_charge + SPK + 20, n);
    chk("restart delay", in_win(n, ba_charge + SPK, 10), 1'h1);
    chk("restart switching", switching_en, 1'h0);
    step_fb(lvl(1400, 1500));
    wait_for(B_CELL, 1'h1, 60, n);
    chk("cell at turn-off", startup_cell_en, 1'h1);
    wait_for(B_SOFT, 1'h1, 60, n);
    chk("soft start req", soft_start_req, 1'h1);
    chk("cell at turn-on", startup_cell_en, 1'h0);
    wait_normal(q);
    chk("resume normal", q[4:0], ST_NORMAL);
    // Immediate faults, external one masked first
    for (i = 0; i < 5; i++) begin
      if (i == 4) begin
        ahb(1'h1, {20'h0, ADDR_CTRL}, 32'h0, q);
        @(posedge hclk);
        flt <= 5'h10;
        repeat (12) @(negedge hclk);
        chk("masked fault", restart_request, 1'h0);
        ahb(1'h1, {20'h0, ADDR_CTRL}, 32'h1, q);
      end else begin
        @(posedge hclk);
        flt <= 5'(1 << i);
      end
      wait_for(B_RST, 1'h1, 8, n);
      chk("fault restart", restart_request, 1'h1);
      if (i == 1) begin
        wait_for(B_SOFT, 1'h1, 80, n);
        wait_for(B_RST, 1'h1, 40, n);
        chk("fault persists", restart_request, 1'h1);
      end
      @(posedge hclk);
      flt <= 5'h00;
      wait_normal(q);
      chk("fault cleared", q[4:0], ST_NORMAL);
    end
    test_done();
  end
endmodule : tb_top
